// >>> rtl/ssp_pkg.sv
// package: opcodes, field layout, reset values and wait times of the serial program decoder
package ssp_pkg;
    // first and second instruction bytes
    localparam logic [7:0] OP_ACCESS = 8'hAC;
    localparam logic [7:0] EN_KEY = 8'h53;
    localparam logic [2:0] ERASE_TAG = 3'h4;
    localparam logic [2:0] LOCK_TAG = 3'h7;
    localparam logic [7:0] FUSE_LO_TAG = 8'hA0;
    localparam logic [7:0] FUSE_HI_TAG = 8'hA8;
    localparam logic [7:0] OP_FL_RD = 8'h20;
    localparam logic [7:0] OP_PG_LD = 8'h40;
    localparam logic [7:0] OP_PG_WR = 8'h4C;
    localparam logic [7:0] OP_EE_RD = 8'hA0;
    localparam logic [7:0] OP_EE_WR = 8'hC0;
    localparam logic [7:0] OP_LOCK_RD = 8'h58;
    localparam logic [7:0] OP_FUSE_RD = 8'h50;
    localparam logic [7:0] OP_CAL_RD = 8'h38;
    localparam logic [7:0] OP_SIG_RD = 8'h30;
    localparam logic [7:0] SEL_ZERO = 8'h00;
    localparam logic [7:0] SEL_FUSE_HI = 8'h08;
    localparam logic [7:0] HSEL_MASK = 8'hF7;
    localparam int HSEL_BIT = 3;
    // memory geometry
    localparam int PAGE_AW = 6;
    localparam int PAGE_WORDS = 64;
    localparam int FLASH_AW = 14;
    localparam int EE_AW = 10;
    // reset and erased values
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] FUSE_RST = 8'hFF;
    localparam logic [5:0] LOCK_RST = 6'h3F;
    localparam logic [1:0] LOCK_PAD = 2'h3;
    // least wait times after writes, in ms, and their cycle counts at clk_sys
    localparam real CLK_SYS_MHZ = 40.0;
    localparam real FLASH_WRITE_WAIT_MS = 4.5;
    localparam real EEPROM_WRITE_WAIT_MS = 9.0;
    localparam real ERASE_WAIT_MS = 9.0;
    localparam real FUSE_WRITE_WAIT_MS = 4.5;
    localparam int FLASH_WRITE_WAIT_CYC = int'($ceil(FLASH_WRITE_WAIT_MS * 1000.0 * CLK_SYS_MHZ));
    localparam int EEPROM_WRITE_WAIT_CYC = int'($ceil(EEPROM_WRITE_WAIT_MS * 1000.0 * CLK_SYS_MHZ));
    localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * 1000.0 * CLK_SYS_MHZ));
    localparam int FUSE_WRITE_WAIT_CYC = int'($ceil(FUSE_WRITE_WAIT_MS * 1000.0 * CLK_SYS_MHZ));
    typedef logic [18:0] ssp_wait_t;
    // one instruction, byte 1 first
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } ssp_instr_s;
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } ssp_hdr_s;
endpackage : ssp_pkg

// >>> rtl/ssp_prog_decoder.sv
// serial programming instruction decoder with its instruction fifo
// Notes on behaviour
// - enable instruction must come first in programming
// - erase command clears whole flash and eeprom
// - flash read returns selected byte in byte four
// - page load stores byte four, low half first
// - page write commits buffer to addressed page
// - eeprom read returns addressed byte in byte four
// - eeprom write stores byte four at address
// - lock read returns six lock bits
// - lock write programs bits written as zero
// - fuse writes update low or high fuse
// - fuse reads return low or high fuse
// - calibration read returns selected calibration byte
// - sample on sck rise, shift out on fall
// - echo enable key while third byte shifts
// - reads inside page being written give ones
`timescale 1ns/100ps
`default_nettype none

// synchronous fifo; back-pressure shows as in_ready low when full
module ssp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } ssp_fifo_s;
    ssp_fifo_s q, d;
    logic push;
    logic pop;

    // pointers wrap at DEPTH so any depth works, not only powers of two
    always_comb begin
        d = q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rd];
endmodule : ssp_fifo

module ssp_prog_decoder #(
    parameter int FIFO_DEPTH = 4,
    parameter int FLASH_WAIT = ssp_pkg::FLASH_WRITE_WAIT_CYC,
    parameter int EEPROM_WAIT = ssp_pkg::EEPROM_WRITE_WAIT_CYC,
    parameter int ERASE_WAIT = ssp_pkg::ERASE_WAIT_CYC,
    parameter int FUSE_WAIT = ssp_pkg::FUSE_WRITE_WAIT_CYC,
    parameter logic [23:0] SIG_BYTES = 24'h123456 // arbitrary identity value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic spi_sck,
    input wire logic mosi,
    output logic miso,
    input wire logic [31:0] osc_cal,
    output logic prog_mode,
    output logic busy,
    output logic [7:0] fuse_lo,
    output logic [7:0] fuse_hi,
    output logic [5:0] lock_bits
);
    typedef enum {EX_IDLE, EX_WAIT} ssp_exec_e;
    typedef struct packed {
        logic [4:0] cnt;
        logic [30:0] sh;
        ssp_pkg::ssp_hdr_s hdr;
        ssp_pkg::ssp_instr_s instr;
        logic hdr_tgl;
        logic ins_tgl;
    } ssp_link_s;
    typedef struct packed {
        logic [1:0] pin_sync;
        logic [2:0] hdr_sync;
        logic [2:0] ins_sync;
        logic prog_en;
        logic pend;
        ssp_pkg::ssp_instr_s pend_w;
        ssp_exec_e state;
        ssp_pkg::ssp_wait_t cnt;
        logic commit;
        logic page_busy;
        logic [7:0] page;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [5:0] lock;
        logic [7:0] rdata;
    } ssp_sys_s;

    ssp_link_s lq, ld;
    logic [7:0] tx_q, tx_d;
    ssp_sys_s q, d;
    logic [15:0] fl_mem [2**ssp_pkg::FLASH_AW];
    logic [7:0] ee_mem [2**ssp_pkg::EE_AW];
    logic [15:0] pg_buf [ssp_pkg::PAGE_WORDS];
    logic in_ready, out_valid, out_ready, pop;
    ssp_pkg::ssp_instr_s w;
    logic ee_we, pg_we, fl_commit, erase;
    logic [ssp_pkg::EE_AW-1:0] ee_wa;
    logic [ssp_pkg::PAGE_AW-1:0] pg_wa;
    ssp_pkg::ssp_hdr_s h;
    logic [ssp_pkg::FLASH_AW-1:0] fl_ra;
    logic [15:0] fl_word;

    // link side: shift on rising sck, msb first, frame every 32 bits
    always_comb begin
        ld = lq;
        ld.sh = {lq.sh[29:0], mosi};
        ld.cnt = lq.cnt + 5'h01;
        if (lq.cnt == 5'h17) begin
            ld.hdr = {lq.sh[22:0], mosi}; // three bytes known: reply can be prepared
            ld.hdr_tgl = !lq.hdr_tgl;
        end
        if (lq.cnt == 5'h1F) begin
            ld.instr = {lq.sh, mosi};
            ld.ins_tgl = !lq.ins_tgl;
        end
    end

    // link logic is held clear while the reset pin is high, since sck may stand still then
    always_ff @(posedge spi_sck or posedge reset_pin_n) begin
        if (reset_pin_n) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // outgoing byte changes on falling sck; the reply byte is quasi-static by then
    always_comb begin
        tx_d = {tx_q[6:0], 1'b0};
        if (lq.cnt == 5'h10) begin
            tx_d = (lq.sh[15:0] == {ssp_pkg::OP_ACCESS, ssp_pkg::EN_KEY}) ? lq.sh[7:0] : 8'h00;
        end else if (lq.cnt == 5'h18) begin
            tx_d = q.rdata;
        end
    end

    always_ff @(negedge spi_sck or posedge reset_pin_n) begin
        if (reset_pin_n) begin
            tx_q <= 8'h00;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign miso = tx_q[7];

    ssp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(q.pend),
        .in_ready(in_ready),
        .in_data(q.pend_w),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(w)
    );

    // read lookup on the header handed over by toggle; link holds it stable meanwhile
    assign h = lq.hdr;
    assign fl_ra = {h.b2[5:0], h.b3};
    assign fl_word = fl_mem[fl_ra];
    assign out_ready = (q.state == EX_IDLE);
    assign pop = out_valid && out_ready;
    assign ee_wa = {w.b2[1:0], w.b3};
    assign pg_wa = w.b3[5:0];

    always_comb begin
        d = q;
        ee_we = 1'b0;
        pg_we = 1'b0;
        fl_commit = 1'b0;
        erase = 1'b0;
        d.pin_sync = {q.pin_sync[0], reset_pin_n};
        d.hdr_sync = {q.hdr_sync[1:0], lq.hdr_tgl};
        d.ins_sync = {q.ins_sync[1:0], lq.ins_tgl};
        if (q.hdr_sync[2] != q.hdr_sync[1]) begin
            d.rdata = 8'h00;
            if (q.prog_en) begin
                if ((h.b1 & ssp_pkg::HSEL_MASK) == ssp_pkg::OP_FL_RD) begin
                    if (q.page_busy && (q.page == fl_ra[13:6])) begin
                        d.rdata = ssp_pkg::ERASED_BYTE;
                    end else begin
                        d.rdata = h.b1[ssp_pkg::HSEL_BIT] ? fl_word[15:8] : fl_word[7:0];
                    end
                end else if (h.b1 == ssp_pkg::OP_EE_RD) begin
                    d.rdata = ee_mem[{h.b2[1:0], h.b3}];
                end else if (h.b1 == ssp_pkg::OP_LOCK_RD && h.b2 == ssp_pkg::SEL_ZERO) begin
                    d.rdata = {ssp_pkg::LOCK_PAD, q.lock};
                end else if (h.b1 == ssp_pkg::OP_LOCK_RD && h.b2 == ssp_pkg::SEL_FUSE_HI) begin
                    d.rdata = q.fuse_hi;
                end else if (h.b1 == ssp_pkg::OP_FUSE_RD && h.b2 == ssp_pkg::SEL_ZERO) begin
                    d.rdata = q.fuse_lo;
                end else if (h.b1 == ssp_pkg::OP_CAL_RD) begin
                    d.rdata = osc_cal[8*h.b3[1:0] +: 8];
                end else if (h.b1 == ssp_pkg::OP_SIG_RD && h.b3[1:0] != 2'h3) begin
                    d.rdata = SIG_BYTES[8*(2 - h.b3[1:0]) +: 8];
                end
            end
        end
        // a finished frame waits here until the fifo has room
        if (q.pend && in_ready) begin
            d.pend = 1'b0;
        end
        if (q.ins_sync[2] != q.ins_sync[1]) begin
            d.pend = 1'b1;
            d.pend_w = lq.instr;
        end
        // executor: one instruction at a time, stalls for the write delays
        case (q.state)
            EX_IDLE: begin
                if (pop && !q.prog_en) begin
                    d.prog_en = (w.b1 == ssp_pkg::OP_ACCESS) && (w.b2 == ssp_pkg::EN_KEY);
                end else if (pop && w.b1 == ssp_pkg::OP_ACCESS) begin
                    if (w.b2[7:5] == ssp_pkg::ERASE_TAG) begin
                        erase = 1'b1;
                        d.lock = ssp_pkg::LOCK_RST;
                        d.state = EX_WAIT;
                        d.cnt = ssp_pkg::ssp_wait_t'(ERASE_WAIT);
                    end else if (w.b2[7:5] == ssp_pkg::LOCK_TAG) begin
                        d.lock = q.lock & w.b4[5:0];
                        d.state = EX_WAIT;
                        d.cnt = ssp_pkg::ssp_wait_t'(FUSE_WAIT);
                    end else if (w.b2 == ssp_pkg::FUSE_LO_TAG || w.b2 == ssp_pkg::FUSE_HI_TAG) begin
                        if (w.b2 == ssp_pkg::FUSE_LO_TAG) begin
                            d.fuse_lo = w.b4;
                        end else begin
                            d.fuse_hi = w.b4;
                        end
                        d.state = EX_WAIT;
                        d.cnt = ssp_pkg::ssp_wait_t'(FUSE_WAIT);
                    end
                end else if (pop && (w.b1 & ssp_pkg::HSEL_MASK) == ssp_pkg::OP_PG_LD) begin
                    pg_we = 1'b1;
                end else if (pop && w.b1 == ssp_pkg::OP_PG_WR) begin
                    d.page = {w.b2[5:0], w.b3[7:6]};
                    d.page_busy = 1'b1;
                    d.commit = 1'b1;
                    d.state = EX_WAIT;
                    d.cnt = ssp_pkg::ssp_wait_t'(FLASH_WAIT);
                end else if (pop && w.b1 == ssp_pkg::OP_EE_WR) begin
                    ee_we = 1'b1;
                    d.state = EX_WAIT;
                    d.cnt = ssp_pkg::ssp_wait_t'(EEPROM_WAIT);
                end
            end
            EX_WAIT: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt <= ssp_pkg::ssp_wait_t'(1)) begin
                    d.state = EX_IDLE;
                    fl_commit = q.commit; // page lands only when the delay has run out
                    d.commit = 1'b0;
                    d.page_busy = 1'b0;
                end
            end
            default: begin
                d.state = EX_IDLE;
            end
        endcase
        // leaving programming drops the enable; the next session starts over
        if (q.pin_sync[1]) begin
            d.prog_en = 1'b0;
            d.pend = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
            q.state <= EX_IDLE;
            q.fuse_lo <= ssp_pkg::FUSE_RST;
            q.fuse_hi <= ssp_pkg::FUSE_RST;
            q.lock <= ssp_pkg::LOCK_RST;
            // sync chains keep tracking the link toggles, so a core reset sees no false edge
            q.hdr_sync <= d.hdr_sync;
            q.ins_sync <= d.ins_sync;
        end else begin
            q <= d;
        end
    end

    // arrays are plain storage, no reset; erase is the way to a known flash and eeprom content
    always_ff @(posedge clk_sys) begin
        if (erase) begin
            for (int i = 0; i < 2**ssp_pkg::FLASH_AW; i++) begin
                fl_mem[i] <= ssp_pkg::ERASED_WORD;
            end
            for (int i = 0; i < 2**ssp_pkg::EE_AW; i++) begin
                ee_mem[i] <= ssp_pkg::ERASED_BYTE;
            end
        end else begin
            if (fl_commit) begin
                for (int i = 0; i < ssp_pkg::PAGE_WORDS; i++) begin
                    fl_mem[{q.page, ssp_pkg::PAGE_AW'(i)}] <= pg_buf[i];
                end
            end
            if (ee_we) begin
                ee_mem[ee_wa] <= w.b4;
            end
        end
        if (pg_we) begin
            if (w.b1[ssp_pkg::HSEL_BIT]) begin
                pg_buf[pg_wa][15:8] <= w.b4;
            end else begin
                pg_buf[pg_wa][7:0] <= w.b4;
            end
        end
    end

    assign prog_mode = q.prog_en;
    assign busy = (q.state == EX_WAIT);
    assign fuse_lo = q.fuse_lo;
    assign fuse_hi = q.fuse_hi;
    assign lock_bits = q.lock;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_enable_pop;
        pop && !q.prog_en && w.b1 == ssp_pkg::OP_ACCESS && w.b2 == ssp_pkg::EN_KEY;
    endsequence
    sequence s_page_wr_pop;
        pop && q.prog_en && w.b1 == ssp_pkg::OP_PG_WR;
    endsequence
    sequence s_hdr_in;
        q.hdr_sync[2] != q.hdr_sync[1];
    endsequence

    enable_entry_a: assert property ((s_enable_pop and !q.pin_sync[1]) |=> q.prog_en)
        else $error("enable instruction did not enter programming");
    locked_ignore_a: assert property (pop && !q.prog_en |=> $stable(q.fuse_lo) && $stable(q.lock))
        else $error("instruction acted before programming was enabled");
    erase_wait_a: assert property (pop && q.prog_en && w.b1 == ssp_pkg::OP_ACCESS
        && w.b2[7:5] == ssp_pkg::ERASE_TAG |=> busy && q.cnt == ssp_pkg::ssp_wait_t'(ERASE_WAIT))
        else $error("chip erase did not start its wait");
    page_hold_a: assert property (s_page_wr_pop |=> q.page_busy [*8])
        else $error("page busy dropped too early");
    page_addr_a: assert property (s_page_wr_pop |=> q.page == {$past(w.b2[5:0]), $past(w.b3[7:6])})
        else $error("page write took the wrong page");
    busy_read_a: assert property (s_hdr_in and (q.prog_en && q.page_busy
        && (h.b1 & ssp_pkg::HSEL_MASK) == ssp_pkg::OP_FL_RD && q.page == fl_ra[13:6])
        |=> q.rdata == ssp_pkg::ERASED_BYTE)
        else $error("read inside busy page did not give ones");
    fuse_read_a: assert property (s_hdr_in and (q.prog_en && h.b1 == ssp_pkg::OP_FUSE_RD
        && h.b2 == ssp_pkg::SEL_ZERO) |=> q.rdata == $past(q.fuse_lo))
        else $error("low fuse read returned wrong value");
    lock_write_a: assert property (pop && q.prog_en && w.b1 == ssp_pkg::OP_ACCESS
        && w.b2[7:5] == ssp_pkg::LOCK_TAG |=> q.lock == ($past(q.lock) & $past(w.b4[5:0])))
        else $error("lock write did not program zero bits");
    ee_write_a: assert property (pop && q.prog_en && w.b1 == ssp_pkg::OP_EE_WR
        |=> ee_mem[$past(ee_wa)] == $past(w.b4) ##1 busy)
        else $error("eeprom write lost its data");
    exit_drop_a: assert property (q.pin_sync[1] |=> !q.prog_en)
        else $error("programming stayed enabled with reset pin high");
endmodule : ssp_prog_decoder
`default_nettype wire

// >>> verif/ssp_programmer.sv
// programmer model: drives four-byte instructions over the serial link
`timescale 1ns/100ps
`default_nettype none

module ssp_programmer (
    input wire logic slow,
    input wire logic miso,
    output logic spi_sck,
    output logic mosi,
    output logic [7:0] echo,
    output logic [7:0] reply,
    output logic frame_done
);
    // sck idles low so no stray edge reaches the link before the first frame
    initial begin
        spi_sck = 1'b0;
        mosi = 1'b0;
        echo = 8'h00;
        reply = 8'h00;
        frame_done = 1'b0;
    end

    // all four bytes always go out, whatever the echo shows
    task automatic xfer(input logic [31:0] ins);
        realtime half;
        logic [31:0] rx;
        half = slow ? 20.0 : 3.0;
        rx = 32'h00000000;
        for (int i = 31; i >= 0; i--) begin
            mosi = ins[i];
            #half;
            spi_sck = 1'b1;
            rx[i] = miso;
            // long high time after edge 24 gives the core time to fetch the reply
            if (i == 8) #200;
            #half;
            spi_sck = 1'b0;
        end
        // clock stands still now; data line no longer carries the last bit
        mosi = ~mosi;
        echo = rx[15:8];
        reply = rx[7:0];
        frame_done = 1'b1;
        #1;
        frame_done = 1'b0;
    endtask : xfer
endmodule : ssp_programmer

`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the serial program decoder and its fifo
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clk_sys;
    logic rst;
    logic reset_pin_n;
    logic [31:0] osc_cal;
    logic slow;
    logic spi_sck;
    logic mosi;
    logic miso;
    logic prog_mode;
    logic busy;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [5:0] lock_bits;
    logic [7:0] echo;
    logic [7:0] reply;
    logic frame_done;
    logic [31:0] note_q[$];
    logic [31:0] nt;
    logic [7:0] pg;
    logic [7:0] d8[4];
    logic [9:0] ea;
    logic [5:0] lk;
    logic [5:0] lexp;
    int n_errors;
    int comparisons;
    int cycles;
    int seed;

    localparam logic [23:0] SIG_VAL = 24'h5A3C96; // arbitrary identity value

    // waits shortened so the run stays brief
    ssp_prog_decoder #(.FLASH_WAIT(200), .EEPROM_WAIT(300), .ERASE_WAIT(300), .FUSE_WAIT(100),
        .SIG_BYTES(SIG_VAL))
    i_dut (.clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n), .spi_sck(spi_sck),
        .mosi(mosi), .miso(miso), .osc_cal(osc_cal), .prog_mode(prog_mode), .busy(busy),
        .fuse_lo(fuse_lo), .fuse_hi(fuse_hi), .lock_bits(lock_bits));
    ssp_programmer i_prog (.slow(slow), .miso(miso), .spi_sck(spi_sck), .mosi(mosi),
        .echo(echo), .reply(reply), .frame_done(frame_done));

    // 40 MHz system clock
    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        comparisons++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic conclude;
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // note expected echo and reply, shift the frame, then leave the frame gap
    task automatic send(input logic [31:0] ins, input logic [7:0] rm, input logic [7:0] rv);
        logic [7:0] ex;
        ex = (ins[31:16] == {ssp_pkg::OP_ACCESS, ssp_pkg::EN_KEY}) ? ssp_pkg::EN_KEY : 8'h00;
        note_q.push_back({8'hFF, ex, rm, rv});
        i_prog.xfer(ins);
        repeat (12) @(negedge clk_sys);
    endtask : send

    // bounded wait for the write delay to run out
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 1000) begin
            @(negedge clk_sys);
            k++;
        end
        check8({7'h00, busy}, 8'h00, 8'hFF);
    endtask : wait_idle

    // each finished frame takes the oldest note
    always @(posedge frame_done) begin
        if (note_q.size() == 0) begin
            check32(32'(note_q.size()), 32'h00000001);
        end else begin
            nt = note_q.pop_front();
            check8(echo, nt[23:16], nt[31:24]);
            check8(reply, nt[7:0], nt[15:8]);
        end
    end

    // whole run needs a few thousand cycles; this ceiling only catches a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        seed = 32'hA2B6F226;
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        reset_pin_n = 1'b0;
        slow = 1'b0;
        osc_cal = $random(seed);
        // a pulse on the reset pin clears the link logic, which rst does not reach
        @(negedge clk_sys);
        reset_pin_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        reset_pin_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check8(fuse_lo, ssp_pkg::FUSE_RST, 8'hFF);
        check8(fuse_hi, ssp_pkg::FUSE_RST, 8'hFF);
        check8({2'b00, lock_bits}, {2'b00, ssp_pkg::LOCK_RST}, 8'hFF);
        check8({6'h00, prog_mode, busy}, 8'h00, 8'hFF);
        // writes and reads before enable are ignored
        send({ssp_pkg::OP_ACCESS, ssp_pkg::FUSE_LO_TAG, 16'h005A}, 8'h00, 8'h00);
        send({ssp_pkg::OP_FUSE_RD, ssp_pkg::SEL_ZERO, 16'h0000}, 8'hFF, 8'h00);
        check8(fuse_lo, ssp_pkg::FUSE_RST, 8'hFF);
        send({ssp_pkg::OP_ACCESS, ssp_pkg::EN_KEY, 16'($random(seed))}, 8'h00, 8'h00);
        check8({7'h00, prog_mode}, 8'h01, 8'hFF);
        send({ssp_pkg::OP_ACCESS, ssp_pkg::ERASE_TAG, 5'h1F, 16'h0000}, 8'h00, 8'h00);
        send({ssp_pkg::OP_EE_RD, 6'h00, 10'($random(seed)), 8'h00}, 8'hFF, 8'hFF);
        // loads queue behind the erase: fifo fills, the last one waits in the hold register
        pg = $random(seed);
        for (int k = 0; k < 4; k++) begin
            d8[k] = $random(seed);
            send({ssp_pkg::OP_PG_LD | {4'h0, k[0], 3'h0}, 8'h00, {2'b00, {6{k[1]}}}, d8[k]},
                8'h00, 8'h00);
        end
        check8({7'h00, busy}, 8'h01, 8'hFF);
        wait_idle();
        send({ssp_pkg::OP_FL_RD, 2'b00, 14'($random(seed)), 8'h00}, 8'hFF, 8'hFF);
        send({ssp_pkg::OP_PG_WR, 2'b00, pg, 14'h0000}, 8'h00, 8'h00);
        check8({7'h00, busy}, 8'h01, 8'hFF);
        send({ssp_pkg::OP_FL_RD, 2'b00, pg, 6'h00, 8'h00}, 8'hFF, ssp_pkg::ERASED_BYTE);
        wait_idle();
        slow = 1'b1;
        for (int k = 0; k < 4; k++) begin
            send({ssp_pkg::OP_FL_RD | {4'h0, k[0], 3'h0}, 2'b00, pg, {6{k[1]}}, 8'h00},
                8'hFF, d8[k]);
        end
        slow = 1'b0;
        // eeprom at a random place and at the top address
        for (int j = 0; j < 2; j++) begin
            ea = j ? 10'h3FF : 10'($random(seed));
            d8[0] = $random(seed);
            send({ssp_pkg::OP_EE_WR, 6'h00, ea, d8[0]}, 8'h00, 8'h00);
            wait_idle();
            send({ssp_pkg::OP_EE_RD, 6'h00, ea, 8'h00}, 8'hFF, d8[0]);
        end
        // lock writes only ever program bits
        lexp = ssp_pkg::LOCK_RST;
        for (int j = 0; j < 2; j++) begin
            lk = $random(seed);
            lexp = lexp & lk;
            send({ssp_pkg::OP_ACCESS, ssp_pkg::LOCK_TAG, 13'h0000, 2'b11, lk},
                8'h00, 8'h00);
            wait_idle();
            check8({2'b00, lock_bits}, {2'b00, lexp}, 8'hFF);
            send({ssp_pkg::OP_LOCK_RD, 24'h000000}, 8'h3F, {2'b11, lexp});
        end
        for (int j = 0; j < 2; j++) begin
            d8[0] = $random(seed);
            send({ssp_pkg::OP_ACCESS, j ? ssp_pkg::FUSE_HI_TAG : ssp_pkg::FUSE_LO_TAG,
                8'h00, d8[0]}, 8'h00, 8'h00);
            wait_idle();
            check8(j ? fuse_hi : fuse_lo, d8[0], 8'hFF);
            send({j ? ssp_pkg::OP_LOCK_RD : ssp_pkg::OP_FUSE_RD,
                j ? ssp_pkg::SEL_FUSE_HI : ssp_pkg::SEL_ZERO, 16'h0000}, 8'hFF, d8[0]);
        end
        // calibration byte, then signature byte, for each index; index 3 has no signature byte
        for (int k = 0; k < 4; k++) begin
            send({ssp_pkg::OP_CAL_RD, 8'h00, 6'h00, k[1:0], 8'h00},
                8'hFF, osc_cal[8*k +: 8]);
            send({ssp_pkg::OP_SIG_RD, 8'h00, 6'h00, k[1:0], 8'h00},
                8'hFF, (k == 3) ? 8'h00 : SIG_VAL[8*(2-k) +: 8]);
        end
        // resync by a pulse on the reset pin, then a core reset in mid-run
        reset_pin_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check8({7'h00, prog_mode}, 8'h00, 8'hFF);
        reset_pin_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        send({ssp_pkg::OP_ACCESS, ssp_pkg::EN_KEY, 16'h0000}, 8'h00, 8'h00);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        // the last frame must not be taken again once the core reset is over
        repeat (6) @(negedge clk_sys);
        check8(fuse_hi, ssp_pkg::FUSE_RST, 8'hFF);
        check8({7'h00, prog_mode}, 8'h00, 8'hFF);
        check32(32'(note_q.size()), 32'h00000000);
        conclude();
    end
endmodule : testbench

`default_nettype wire
